// ### verilog/reset_watchdog_pkg.sv
// Constants and types for the reset sequencer and software watchdog.
package reset_watchdog_pkg;
    // ****************************************
    // Timing in E clock cycles (clk_i is the E clock) and counter widths in bits
    // ****************************************
    localparam int POR_SHORT_CYC = 128;
    localparam int POR_LONG_CYC = 4064;
    localparam int DRIVE_CYC = 8;
    localparam int SAMPLE_CYC = 4;
    localparam int EXT_MIN_CYC = 16;
    localparam int WRITE_WIN_CYC = 64;
    localparam int PRESCALE_BITS = 15;
    localparam int CNT_W = 12;
    localparam int WD_W = 9;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_OPTIONS = 8'h00;
    localparam logic [7:0] OFS_SERVICE = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_TEST = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OPTIONS_RESET = 8'h10;
    localparam int RATE_LSB = 0;
    localparam int DISABLE_BIT = 0;
    localparam int DISABLE_RESETS_BIT_BIT = 0;
    localparam logic [7:0] SERVICE_ARM = 8'h55;
    localparam logic [7:0] SERVICE_CLEAR = 8'hAA;
    // ****************************************
    // Synchroniser lanes
    // ****************************************
    localparam int SY_PIN = 0;
    localparam int SY_CLKMON = 1;
    localparam int SY_STRAP = 2;
    localparam int SY_PLL = 3;
    localparam int SY_SPECIAL = 4;
    localparam int SY_W = 5;
    typedef enum logic [1:0] {
        SRC_NORMAL = 2'h0,
        SRC_WATCHDOG = 2'h1,
        SRC_CLKMON = 2'h2
    } reset_src_type;
    typedef enum logic [2:0] {
        S_POR = 3'h0,
        S_PINWAIT = 3'h1,
        S_RUN = 3'h3,
        S_DRIVE = 3'h2,
        S_SETTLE = 3'h6
    } seq_state_type;
endpackage

// ### verilog/reset_watchdog.sv
// Reset sequencer with open-drain reset pin and software watchdog.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Power-on and external resets use normal vector; watchdog and monitor own.
// - After power-on hold reset for 128 or 4064 cycles per strap.
// - Pin still low after power-on delay keeps CPU in reset.
// - Any reset other than power-on drives the pin low for eight cycles then releases.
// - Four cycles after release pin low means external, high internal.
// - Unserviced enabled watchdog expiring starts a system reset.
// - Watchdog enable follows the disable bit latched at system reset.
// - Special modes start with watchdog resets inhibited; writing zero enables them.
// - Watchdog clock is E/2^15, or timer A underflows with PLL.
// - Without PLL rate codes scale by 1, 4, 16, 64.
// - With PLL rate codes divide by 4, 16, 64, 256.
// - Reset clears rate; normal modes allow one write within 64 cycles.
// - Timeout never short of nominal, at most one tick longer.
// - Rate select sits in options bits 1:0; options reset 0x10.
module reset_watchdog
    import reset_watchdog_pkg::*;
#(
    parameter logic DISABLE_DEFAULT = 1'b0
) (
    input wire logic clk_i,               // E clock
    input wire logic rst_b_i,             // Power-on reset, low
    input wire logic psel_i,              // APB select
    input wire logic penable_i,           // APB enable
    input wire logic pwrite_i,            // APB direction
    input wire logic [7:0] paddr_i,       // APB byte address
    input wire logic [31:0] pwdata_i,     // APB write data
    output logic [31:0] prdata_o,         // APB read data
    output logic pready_o,                // APB ready
    output logic pslverr_o,               // APB error
    input wire logic reset_pin_i,         // Reset pin level
    output logic reset_pin_o,             // Reset pin drive level
    output logic reset_pin_oe_o,          // Reset pin pull-low enable
    input wire logic clkmon_fail_i,       // Clock monitor failure
    input wire logic long_delay_i,        // Strap: long power-on delay
    input wire logic pll_supply_enable_i, // PLL in use
    input wire logic special_mode_i,      // Special test or bootstrap
    input wire logic timer_a_output_clock_i, // Timer A underflow pulse
    output logic cpu_reset_o,             // CPU held in reset
    output logic [1:0] vector_sel_o       // Vector selection
);
    // Scale factor in watchdog clock ticks for a rate code.
    function automatic logic [WD_W-1:0] wd_scale(input logic [1:0] rs,
                                                 input logic pll);
        logic [WD_W-1:0] base;
        base = pll ? WD_W'(4) : WD_W'(1);
        wd_scale = base << {rs, 1'b0};
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SY_W-1:0] meta_ff, sync_ff;
    always_ff @(posedge clk_i) begin
        meta_ff <= {special_mode_i, pll_supply_enable_i, long_delay_i,
                    clkmon_fail_i, reset_pin_i};
        sync_ff <= meta_ff;
    end
    logic pin_hi, pll_on, special;
    assign pin_hi = sync_ff[SY_PIN];
    assign pll_on = sync_ff[SY_PLL];
    assign special = sync_ff[SY_SPECIAL];

    // ****************************************
    // State
    // ****************************************
    seq_state_type state_ff, nxt_state;
    reset_src_type src_ff, nxt_src;
    reset_src_type pend_ff, nxt_pend;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [PRESCALE_BITS-1:0] div_ff, nxt_div;
    logic [WD_W-1:0] wd_cnt_ff, nxt_wd_cnt;
    logic [6:0] win_ff, nxt_win;
    logic [1:0] rate_ff, nxt_rate;
    logic rate_done_ff, nxt_rate_done;
    logic arm_ff, nxt_arm, dis_pend_ff, nxt_dis_pend;
    logic dis_act_ff, nxt_dis_act, disable_resets_bit_ff, nxt_disable_resets_bit;
    logic oe_ff, nxt_oe, cpu_rst_ff, nxt_cpu_rst;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [CNT_W-1:0] por_limit;
    logic wd_tick, wd_run, wd_timeout;
    logic wr_now, wr_options, wr_service, hit;
    logic [31:0] rd_val;
    assign por_limit = sync_ff[SY_STRAP] ? CNT_W'(POR_LONG_CYC - 1)
                                         : CNT_W'(POR_SHORT_CYC - 1);
    assign wd_tick = pll_on ? timer_a_output_clock_i : (&div_ff);
    assign wd_run = (state_ff == S_RUN) && !dis_act_ff && !disable_resets_bit_ff;
    // One extra tick so a late-phase first tick never shortens the period.
    assign wd_timeout = wd_run && wd_tick
                        && (wd_cnt_ff == wd_scale(rate_ff, pll_on));
    assign wr_now = psel_i && penable_i && pwrite_i && pready_ff
                    && !pslverr_ff;
    assign wr_options = wr_now && (paddr_i == OFS_OPTIONS);
    assign wr_service = wr_now && (paddr_i == OFS_SERVICE);

    // ****************************************
    // Register read decode
    // ****************************************
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr_i == OFS_OPTIONS) begin
            rd_val[7:0] = {OPTIONS_RESET[7:2], rate_ff};
        end else if (paddr_i == OFS_SERVICE) begin
            rd_val = 32'h0000_0000;
        end else if (paddr_i == OFS_CONFIG) begin
            rd_val[DISABLE_BIT] = dis_act_ff;
        end else if (paddr_i == OFS_TEST) begin
            rd_val[DISABLE_RESETS_BIT_BIT] = disable_resets_bit_ff;
        end else if (paddr_i == OFS_STATUS) begin
            rd_val[3:0] = {arm_ff, wd_run, src_ff};
        end else begin
            hit = 1'b0;
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_src = src_ff;
        nxt_pend = pend_ff;
        nxt_cnt = cnt_ff;
        nxt_div = div_ff + PRESCALE_BITS'(1);
        nxt_wd_cnt = wd_cnt_ff;
        nxt_win = win_ff;
        nxt_rate = rate_ff;
        nxt_rate_done = rate_done_ff;
        nxt_arm = arm_ff;
        nxt_dis_pend = dis_pend_ff;
        nxt_dis_act = dis_act_ff;
        nxt_disable_resets_bit = disable_resets_bit_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        // Bus: registered answer one cycle into the access phase.
        if (psel_i && penable_i && !pready_ff) begin
            nxt_pready = 1'b1;
            nxt_pslverr = !hit;
            if (!pwrite_i) begin
                nxt_prdata = rd_val;
            end
        end
        if (wr_now && paddr_i == OFS_CONFIG) begin
            nxt_dis_pend = pwdata_i[DISABLE_BIT];
        end
        if (wr_now && paddr_i == OFS_TEST && special) begin
            nxt_disable_resets_bit = pwdata_i[DISABLE_RESETS_BIT_BIT];
        end
        if (wr_options && (special || (!rate_done_ff
                && win_ff < 7'(WRITE_WIN_CYC)))) begin
            nxt_rate = pwdata_i[RATE_LSB +: 2];
            nxt_rate_done = !special;
        end
        if (win_ff < 7'(WRITE_WIN_CYC)) begin
            nxt_win = win_ff + 7'(1);
        end
        // Watchdog counting and service sequence.
        if (wd_run && wd_tick && !wd_timeout) begin
            nxt_wd_cnt = wd_cnt_ff + WD_W'(1);
        end
        if (wr_service && pwdata_i[7:0] == SERVICE_ARM) begin
            nxt_arm = 1'b1;
        end else if (wr_service && pwdata_i[7:0] == SERVICE_CLEAR && arm_ff) begin
            nxt_arm = 1'b0;
            nxt_wd_cnt = '0;
        end
        // Sequencer.
        case (state_ff)
            S_POR: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff >= por_limit) begin
                    nxt_src = SRC_NORMAL;
                    nxt_cnt = '0;
                    nxt_state = pin_hi ? S_RUN : S_PINWAIT;
                end
            end
            S_RUN: begin
                if (wd_timeout) begin
                    nxt_pend = SRC_WATCHDOG;
                    nxt_state = S_DRIVE;
                end else if (sync_ff[SY_CLKMON]) begin
                    nxt_pend = SRC_CLKMON;
                    nxt_state = S_DRIVE;
                end else if (!pin_hi) begin
                    nxt_pend = SRC_NORMAL;
                    nxt_state = S_DRIVE;
                end
            end
            S_DRIVE: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff == CNT_W'(DRIVE_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff == CNT_W'(SAMPLE_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_src = pin_hi ? pend_ff : SRC_NORMAL;
                    nxt_state = pin_hi ? S_RUN : S_PINWAIT;
                end
            end
            S_PINWAIT: begin
                if (pin_hi) begin
                    nxt_state = S_RUN;
                end
            end
            default: begin
                nxt_state = S_POR;
            end
        endcase
        // Held system reset reloads latches and restarts the watchdog.
        if (state_ff != S_RUN) begin
            nxt_wd_cnt = '0;
            nxt_arm = 1'b0;
            nxt_rate = 2'h0;
            nxt_rate_done = 1'b0;
            nxt_win = '0;
            nxt_dis_act = dis_pend_ff;
            nxt_disable_resets_bit = special;
        end
        nxt_oe = (nxt_state == S_DRIVE);
        nxt_cpu_rst = (nxt_state != S_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_ff <= S_POR;
            src_ff <= SRC_NORMAL;
            pend_ff <= SRC_NORMAL;
            cnt_ff <= '0;
            div_ff <= '0;
            wd_cnt_ff <= '0;
            win_ff <= '0;
            rate_ff <= 2'h0;
            rate_done_ff <= 1'b0;
            arm_ff <= 1'b0;
            dis_pend_ff <= DISABLE_DEFAULT;
            dis_act_ff <= DISABLE_DEFAULT;
            disable_resets_bit_ff <= 1'b1;
            oe_ff <= 1'b0;
            cpu_rst_ff <= 1'b1;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            src_ff <= nxt_src;
            pend_ff <= nxt_pend;
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            wd_cnt_ff <= nxt_wd_cnt;
            win_ff <= nxt_win;
            rate_ff <= nxt_rate;
            rate_done_ff <= nxt_rate_done;
            arm_ff <= nxt_arm;
            dis_pend_ff <= nxt_dis_pend;
            dis_act_ff <= nxt_dis_act;
            disable_resets_bit_ff <= nxt_disable_resets_bit;
            oe_ff <= nxt_oe;
            cpu_rst_ff <= nxt_cpu_rst;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = oe_ff;
    assign cpu_reset_o = cpu_rst_ff;
    assign vector_sel_o = src_ff;
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [CNT_W-1:0] por_seen_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            por_seen_ff <= '0;
        end else if (state_ff == S_POR) begin
            por_seen_ff <= por_seen_ff + CNT_W'(1);
        end
    end
    sequence pull_low;
        reset_pin_oe_o [*8];
    endsequence
    por_delay_a: assert property (
        (state_ff == S_POR && nxt_state != S_POR) |-> por_seen_ff == por_limit)
        else $error("power-on delay length wrong");
    drive_len_a: assert property (
        $rose(reset_pin_oe_o) |-> pull_low ##1 !reset_pin_oe_o ##3
        (state_ff == S_SETTLE && cnt_ff == CNT_W'(SAMPLE_CYC - 1)))
        else $error("reset pin drive or sample timing wrong");
    pin_hold_a: assert property (
        (state_ff == S_PINWAIT && !pin_hi) |=> cpu_reset_o && !reset_pin_oe_o)
        else $error("reset released while pin low");
    classify_a: assert property (
        (state_ff == S_SETTLE && cnt_ff == CNT_W'(SAMPLE_CYC - 1))
        |=> (vector_sel_o == (($past(pin_hi)) ? $past(pend_ff) : SRC_NORMAL)))
        else $error("reset source classified wrongly");
    wd_fire_a: assert property (
        wd_timeout |=> reset_pin_oe_o && cpu_reset_o && pend_ff == SRC_WATCHDOG)
        else $error("watchdog timeout did not start reset");
    wd_scale_a: assert property (
        wd_timeout |-> wd_cnt_ff == WD_W'(32'h1 << (32'h2 * (rate_ff + pll_on))))
        else $error("watchdog period wrong for rate");
    wd_inhibit_a: assert property (
        (state_ff == S_RUN && (dis_act_ff || disable_resets_bit_ff))
        |=> !(state_ff == S_DRIVE && pend_ff == SRC_WATCHDOG))
        else $error("inhibited watchdog fired");
    rate_clear_a: assert property (
        (cpu_reset_o && $past(cpu_reset_o)) |-> rate_ff == 2'h0 && !arm_ff)
        else $error("rate or arm not cleared by reset");
    rate_lock_a: assert property (
        (wr_options && !special
         && (rate_done_ff || win_ff >= 7'(WRITE_WIN_CYC)))
        |=> $stable(rate_ff))
        else $error("protected rate changed");
    service_a: assert property (
        (wr_service && arm_ff && pwdata_i[7:0] == SERVICE_CLEAR
         && state_ff == S_RUN) |=> wd_cnt_ff == '0 && !arm_ff)
        else $error("service sequence did not clear watchdog");
endmodule
`default_nettype wire

// ### verif/ext_reset_model.sv
// Model of the external reset circuit on the open-drain reset pin.
`timescale 1ns/1ps
`default_nettype none
module ext_reset_model (
    input wire logic hold_low_i,  // Bench asks for the pin low
    input wire logic dut_oe_i,    // Device pulls the pin
    input wire logic dut_level_i, // Device drive level
    output logic pin_o            // Wire level with pull-up
);
    // The pull-up lifts the pin once both parties have let go.
    assign pin_o = (dut_oe_i ? dut_level_i : 1'h1) & ~hold_low_i;
endmodule
`default_nettype wire

// ### verif/reset_watchdog_tb.sv
// Self-checking testbench for the reset sequencer and watchdog.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_tb;
    import reset_watchdog_pkg::*;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pin, pin_drv, pin_oe, cpu_rst;
    logic hold_low = 1'h1, clkmon = 1'h0, tick = 1'h0;
    logic long_dly = 1'h0, pll = 1'h1, special = 1'h0;
    logic [1:0] vsel;
    int failures = 0, cmp_count = 0, cycles = 0, run = 0, last_run = 0;

    always #2 clk_i = ~clk_i;

    reset_watchdog dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .reset_pin_i(pin), .reset_pin_o(pin_drv),
        .reset_pin_oe_o(pin_oe), .clkmon_fail_i(clkmon),
        .long_delay_i(long_dly), .pll_supply_enable_i(pll),
        .special_mode_i(special), .timer_a_output_clock_i(tick),
        .cpu_reset_o(cpu_rst), .vector_sel_o(vsel));

    ext_reset_model ext_u (.hold_low_i(hold_low), .dut_oe_i(pin_oe),
        .dut_level_i(pin_drv), .pin_o(pin));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        check(nm, r, exp);
    endtask

    task automatic wait_cpu(input logic v);
        int n = 0;
        while (cpu_rst !== v && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        check("cpu_reset", cpu_rst, v);
    endtask

    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clk_i);
            tick <= 1'h1;
            @(posedge clk_i);
            tick <= 1'h0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    // Measures how long the device pulls the pin, and cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (pin_oe === 1'h1) begin
            run++;
        end else if (run != 0) begin
            last_run = run;
            run = 0;
        end
        if (cycles >= 90000) begin
            failures++;
            final_report();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_on();
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'h1;
        repeat (120) @(posedge clk_i);
        check("cpu_reset", cpu_rst, 1'h1);
        repeat (80) @(posedge clk_i);
        check("cpu_reset", cpu_rst, 1'h1);
        hold_low <= 1'h0;
        wait_cpu(1'h0);
        check("vector", vsel, 2'h0);
    endtask

    task automatic t_rate();
        logic [31:0] r;
        logic e;
        rd_chk("options", OFS_OPTIONS, {24'h0, OPTIONS_RESET});
        wr(OFS_OPTIONS, 32'h3);
        rd_chk("options", OFS_OPTIONS, 32'h13);
        wr(OFS_OPTIONS, 32'h1);
        rd_chk("options", OFS_OPTIONS, 32'h13);
        wr(OFS_TEST, 32'h1);
        rd_chk("test", OFS_TEST, 32'h0);
        apb(1'h0, 8'h40, 32'h0, r, e);
        check("slverr", e, 1'h1);
    endtask

    task automatic t_watchdog();
        int n;
        last_run = 0;
        wr(OFS_SERVICE, {24'h0, SERVICE_ARM});
        wr(OFS_SERVICE, {24'h0, SERVICE_CLEAR});
        pulse(200);
        wr(OFS_SERVICE, {24'h0, SERVICE_ARM});
        wr(OFS_SERVICE, {24'h0, SERVICE_CLEAR});
        n = 0;
        while (cpu_rst !== 1'h1 && n < 300) begin
            pulse(1);
            n++;
        end
        check("ticks", n, 32'h101);
        wait_cpu(1'h0);
        check("drive_len", last_run, 32'h8);
        check("vector", vsel, 2'h1);
        rd_chk("options", OFS_OPTIONS, 32'h10);
        rd_chk("status", OFS_STATUS, 32'h5);
    endtask

    task automatic t_external();
        last_run = 0;
        hold_low <= 1'h1;
        repeat (20) @(posedge clk_i);
        check("cpu_reset", cpu_rst, 1'h1);
        hold_low <= 1'h0;
        wait_cpu(1'h0);
        check("drive_len", last_run, 32'h8);
        check("pin_drive", pin_drv, 32'h0);
        check("vector", vsel, 2'h0);
    endtask

    task automatic t_clkmon();
        wr(OFS_CONFIG, 32'h1);
        rd_chk("config", OFS_CONFIG, 32'h0);
        last_run = 0;
        clkmon <= 1'h1;
        repeat (4) @(posedge clk_i);
        clkmon <= 1'h0;
        wait_cpu(1'h1);
        wait_cpu(1'h0);
        check("drive_len", last_run, 32'h8);
        check("vector", vsel, 2'h2);
        rd_chk("config", OFS_CONFIG, 32'h1);
        pulse(20);
        check("cpu_reset", cpu_rst, 1'h0);
    endtask

    task automatic t_long_por();
        long_dly <= 1'h1;
        rst_b_i <= 1'h0;
        repeat (5) @(posedge clk_i);
        check("cpu_reset", cpu_rst, 1'h1);
        rst_b_i <= 1'h1;
        repeat (4000) @(posedge clk_i);
        check("cpu_reset", cpu_rst, 1'h1);
        wait_cpu(1'h0);
        check("vector", vsel, 2'h0);
        rd_chk("config", OFS_CONFIG, 32'h0);
    endtask

    task automatic t_slow_clock();
        int n;
        pll <= 1'h0;
        wr(OFS_SERVICE, {24'h0, SERVICE_ARM});
        wr(OFS_SERVICE, {24'h0, SERVICE_CLEAR});
        n = 0;
        while (cpu_rst !== 1'h1) begin
            @(posedge clk_i);
            n++;
        end
        // Up to one extra slow tick, plus two edges of sampling latency.
        check("slow_min", n >= (1 << PRESCALE_BITS), 1'h1);
        check("slow_max", n <= (2 << PRESCALE_BITS) + 2, 1'h1);
        pll <= 1'h1;
        wait_cpu(1'h0);
        check("vector", vsel, 2'h1);
    endtask

    task automatic t_special();
        int n;
        special <= 1'h1;
        hold_low <= 1'h1;
        repeat (20) @(posedge clk_i);
        hold_low <= 1'h0;
        wait_cpu(1'h0);
        rd_chk("test", OFS_TEST, 32'h1);
        pulse(8);
        check("cpu_reset", cpu_rst, 1'h0);
        wr(OFS_OPTIONS, 32'h2);
        wr(OFS_OPTIONS, 32'h1);
        rd_chk("options", OFS_OPTIONS, 32'h11);
        wr(OFS_TEST, 32'h0);
        n = 0;
        while (cpu_rst !== 1'h1 && n < 300) begin
            pulse(1);
            n++;
        end
        check("ticks", n, 32'h11);
        special <= 1'h0;
        wait_cpu(1'h0);
        check("vector", vsel, 2'h1);
    endtask

    initial begin
        t_power_on();
        t_rate();
        t_watchdog();
        t_external();
        t_clkmon();
        t_long_por();
        t_slow_clock();
        t_special();
        final_report();
    end
endmodule
`default_nettype wire
